// File: core/mcdio_cycle_timer.sv
// processing-cycle timer; free runs on its own or realigns to a sync edge
// assumes sync_edge_i is a one-cycle pulse from synchronised logic
`timescale 1ns/10ps
module mcdio_cycle_timer (
  input wire logic sys_clk_i, // block clock
  input wire logic rst_i, // async reset, active high
  input wire logic [15:0] cycle_len_i, // cycle length in clocks
  input wire logic realign_i, // follow mode enabled
  input wire logic sync_edge_i, // sync edge pulse
  output logic tick_o // one-cycle pulse at cycle start
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 16'h0001;
    if (realign_i && sync_edge_i)
    begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end
    else if (!realign_i && (cnt_q >= cycle_len_i - 16'h0001))
    begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule : mcdio_cycle_timer

// File: core/mcdio_pkg.sv
// package of constants for the motion card digital i/o block
// assumes one 200 MHz clock and the plain register port described in the top file
package mcdio_pkg;
  localparam int MCDIO_NUM_AXES = 4;
  localparam int MCDIO_NUM_GP_IN = 2;
  localparam int MCDIO_NUM_IN = 10;
  localparam int MCDIO_NUM_OUT = 3;
  localparam int MCDIO_NUM_IRQ = 3;
  localparam int MCDIO_ADDR_W = 4;
  localparam int MCDIO_DATA_W = 32;
  // register offsets (byte addresses)
  localparam logic [3:0] MCDIO_REG_INPUT = 4'h0;
  localparam logic [3:0] MCDIO_REG_POLARITY = 4'h4;
  localparam logic [3:0] MCDIO_REG_OUTPUT = 4'h8;
  localparam logic [3:0] MCDIO_REG_EXT_STATE = 4'hc;
  // second page of offsets uses the low address bit
  localparam logic [3:0] MCDIO_REG_IRQ_STATUS = 4'h1;
  localparam logic [3:0] MCDIO_REG_IRQ_MASK = 4'h5;
  localparam logic [3:0] MCDIO_REG_SYNC_CTRL = 4'h9;
  localparam logic [3:0] MCDIO_REG_STRAPS = 4'hd;
  // reset values
  localparam logic [9:0] MCDIO_POLARITY_RST = 10'h000;
  localparam logic [2:0] MCDIO_OUTPUT_RST = 3'h0;
  localparam logic [5:0] MCDIO_IRQ_MASK_RST = 6'h00;
  localparam logic [1:0] MCDIO_SYNC_CTRL_RST = 2'h0;
  localparam logic [15:0] MCDIO_CYCLE_LEN_RST = 16'h0fa0;
  // status bit positions
  localparam int MCDIO_ST_EMERGENCY_STOP_N = 0;
  localparam int MCDIO_ST_PROBE0 = 1;
  localparam int MCDIO_ST_PROBE1 = 2;
  localparam int MCDIO_ST_INPUT_CHG = 3;
  localparam int MCDIO_ST_CYCLE = 4;
  localparam int MCDIO_ST_SYNC_LOST = 5;
  localparam int MCDIO_ST_W = 6;
  // sync control bit positions
  localparam int MCDIO_SC_SOURCE = 0;
  localparam int MCDIO_SC_ENABLE = 1;
  // sync pulse width in cycles
  localparam int MCDIO_SYNC_PULSE_CYC = 4;
  localparam logic [MCDIO_DATA_W-1:0] MCDIO_RD_ZERO = 32'h0000_0000;
endpackage : mcdio_pkg

// File: core/mcdio_sync2.sv
// two-flop synchroniser for a vector of independent level inputs
// assumes inputs are quasi-static levels; no bus coherence across bits
`timescale 1ns/10ps
module mcdio_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i, // block clock
  input wire logic rst_i, // async reset, active high
  input wire logic [WIDTH-1:0] async_i, // raw pins
  output logic [WIDTH-1:0] sync_o // synchronised levels
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : mcdio_sync2

// File: core/mcdio_top.sv
// What this block does
// - ten user inputs: plus and minus overtravel per axis, two general ones
// - after reset every user input is active low
// - each input polarity set alone by the input-polarity register
// - three programmable general purpose outputs
// - an output drives low when on and high when off
// - outputs change only through the output-set register and then hold
// - emergency stop and both probes count as asserted when low
// - undriven interrupt inputs read inactive; card works normally
// - source card drives sync output marking its processing cycle
// - two electrically common sync inputs allow daisy chaining
// - encoder strap: one selects differential, zero single ended
//
// top of the motion card digital i/o block: inputs, outputs, interrupts, sync
// assumes a plain register port; pins are pulled up off chip, so idle reads high
`timescale 1ns/10ps
module mcdio_top (
  input wire logic sys_clk_i, // 200 MHz clock
  input wire logic rst_i, // async reset, active high
  input wire logic [mcdio_pkg::MCDIO_NUM_AXES-1:0] ot_pos_n_i, // plus overtravel per axis
  input wire logic [mcdio_pkg::MCDIO_NUM_AXES-1:0] ot_neg_n_i, // minus overtravel per axis
  input wire logic user_input_4_i, // general input 4
  input wire logic user_input_5_i, // general input 5
  input wire logic emergency_stop_n_i, // emergency stop, low active
  input wire logic probe_irq0_n_i, // probe 0, low active
  input wire logic probe_irq1_n_i, // probe 1, low active
  input wire logic sync_in_a_i, // sync input pin a
  input wire logic sync_in_b_i, // sync input pin b, common with a
  input wire logic encoder_mode_strap_i, // 1 differential, 0 single ended
  input wire logic config_strap_one_i, // must be 1 (1-2 fitted)
  input wire logic [mcdio_pkg::MCDIO_ADDR_W-1:0] reg_addr_i, // register address
  input wire logic [mcdio_pkg::MCDIO_DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [mcdio_pkg::MCDIO_DATA_W-1:0] reg_rdata_o, // read data, next cycle
  output logic gp_output_1_o, // output 1, low = on
  output logic gp_output_2_o, // output 2, low = on
  output logic gp_output_3_o, // output 3, low = on
  output logic sync_out_o, // sync output to followers
  output logic encoder_diff_o, // differential encoder mode
  output logic emergency_stop_n_active_o, // emergency stop asserted
  output logic irq_o // level interrupt
);
  import mcdio_pkg::*;

  localparam int RAW_W = MCDIO_NUM_IN + MCDIO_NUM_IRQ + 4;

  logic [RAW_W-1:0] raw_pins;
  logic [RAW_W-1:0] sync_pins;
  logic [MCDIO_NUM_IN-1:0] in_lvl;
  logic [MCDIO_NUM_IRQ-1:0] irq_lvl_n;
  logic sync_in_lvl;
  logic enc_lvl;
  logic cfg1_lvl;
  logic [MCDIO_NUM_IN-1:0] in_on;
  logic [MCDIO_NUM_IRQ-1:0] ext_on;
  logic sync_edge;
  logic tick;

  logic [MCDIO_NUM_IN-1:0] pol_q, pol_d;
  logic [MCDIO_NUM_OUT-1:0] out_q, out_d;
  logic [MCDIO_ST_W-1:0] st_q, st_d;
  logic [MCDIO_ST_W-1:0] msk_q, msk_d;
  logic [1:0] sctl_q, sctl_d;
  logic [15:0] clen_q, clen_d;
  logic [MCDIO_NUM_IN-1:0] in_on_q, in_on_d;
  logic [MCDIO_NUM_IRQ-1:0] ext_q, ext_d;
  logic sync_prev_q, sync_prev_d;
  logic [7:0] pulse_q, pulse_d;
  logic [15:0] watch_q, watch_d;
  logic [MCDIO_DATA_W-1:0] rdata_q, rdata_d;
  logic [2:0] gp_pin_q, gp_pin_d;
  logic sync_out_q, sync_out_d;
  logic enc_q, enc_d;
  logic emergency_stop_n_q, emergency_stop_n_d;
  logic irq_q, irq_d;
  logic [MCDIO_ST_W-1:0] ev;

  // both sync pins are one net
  assign raw_pins = {ot_pos_n_i, ot_neg_n_i, user_input_4_i, user_input_5_i,
                     emergency_stop_n_i, probe_irq0_n_i, probe_irq1_n_i,
                     sync_in_a_i & sync_in_b_i, encoder_mode_strap_i,
                     config_strap_one_i, 1'b1};

  // pins reset to idle high, treated as inactive
  mcdio_sync2 #(
    .WIDTH(RAW_W),
    .RST_VAL({RAW_W{1'b1}})
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i(raw_pins),
    .sync_o(sync_pins)
  );

  // ten inputs: pos[3:0], neg[3:0], gp 4, gp 5
  assign in_lvl = sync_pins[RAW_W-1 -: MCDIO_NUM_IN];
  assign irq_lvl_n = sync_pins[6:4];
  assign sync_in_lvl = sync_pins[3];
  assign enc_lvl = sync_pins[2];
  assign cfg1_lvl = sync_pins[1];

  // polarity bit zero means active low
  assign in_on = in_lvl ^ ~pol_q;

  // emergency stop and probes asserted low
  assign ext_on = ~irq_lvl_n;

  assign sync_edge = sync_in_lvl & ~sync_prev_q;

  // follower realigns to the source cycle
  mcdio_cycle_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cycle_len_i(clen_q),
    .realign_i(sctl_q[MCDIO_SC_ENABLE] & ~sctl_q[MCDIO_SC_SOURCE]),
    .sync_edge_i(sync_edge),
    .tick_o(tick)
  );

  always_comb
  begin
    ev = '0;
    ev[MCDIO_ST_EMERGENCY_STOP_N] = ext_on[2] & ~ext_q[2];
    ev[MCDIO_ST_PROBE0] = ext_on[1] & ~ext_q[1];
    ev[MCDIO_ST_PROBE1] = ext_on[0] & ~ext_q[0];
    ev[MCDIO_ST_INPUT_CHG] = |(in_on ^ in_on_q);
    ev[MCDIO_ST_CYCLE] = tick;
    ev[MCDIO_ST_SYNC_LOST] = (watch_q == 16'hfffe);
  end

  // register writes
  always_comb
  begin
    pol_d = pol_q;
    out_d = out_q;
    msk_d = msk_q;
    sctl_d = sctl_q;
    clen_d = clen_q;
    st_d = st_q;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        MCDIO_REG_POLARITY: pol_d = reg_wdata_i[MCDIO_NUM_IN-1:0];
        MCDIO_REG_OUTPUT: out_d = reg_wdata_i[MCDIO_NUM_OUT-1:0];
        MCDIO_REG_IRQ_STATUS: st_d = st_q & ~reg_wdata_i[MCDIO_ST_W-1:0];
        MCDIO_REG_IRQ_MASK: msk_d = reg_wdata_i[MCDIO_ST_W-1:0];
        MCDIO_REG_SYNC_CTRL:
        begin
          sctl_d = reg_wdata_i[1:0];
          clen_d = reg_wdata_i[31:16];
        end
        default: ;
      endcase
    end
    // set wins over write-one clear
    st_d = st_d | ev;
  end

  // pin-facing state and read data
  always_comb
  begin
    in_on_d = in_on;
    ext_d = ext_on;
    sync_prev_d = sync_in_lvl;
    // source drives a pulse each cycle start
    if (tick && sctl_q[MCDIO_SC_SOURCE] && sctl_q[MCDIO_SC_ENABLE])
      pulse_d = 8'(MCDIO_SYNC_PULSE_CYC);
    else if (pulse_q != 8'h00)
      pulse_d = pulse_q - 8'h01;
    else
      pulse_d = 8'h00;
    sync_out_d = (pulse_d != 8'h00);
    if (sync_edge || !(sctl_q[MCDIO_SC_ENABLE] && !sctl_q[MCDIO_SC_SOURCE]))
      watch_d = 16'h0000;
    else if (watch_q != 16'hffff)
      watch_d = watch_q + 16'h0001;
    else
      watch_d = watch_q;
    gp_pin_d = ~out_d;
    enc_d = enc_lvl;
    emergency_stop_n_d = ext_on[2];
    irq_d = |(st_d & msk_d);
    rdata_d = MCDIO_RD_ZERO;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        MCDIO_REG_INPUT: rdata_d[MCDIO_NUM_IN-1:0] = in_on;
        MCDIO_REG_POLARITY: rdata_d[MCDIO_NUM_IN-1:0] = pol_q;
        MCDIO_REG_OUTPUT: rdata_d[MCDIO_NUM_OUT-1:0] = out_q;
        MCDIO_REG_EXT_STATE: rdata_d[MCDIO_NUM_IRQ-1:0] = ext_on;
        MCDIO_REG_IRQ_STATUS: rdata_d[MCDIO_ST_W-1:0] = st_q;
        MCDIO_REG_IRQ_MASK: rdata_d[MCDIO_ST_W-1:0] = msk_q;
        MCDIO_REG_SYNC_CTRL: rdata_d = {clen_q, 14'h0000, sctl_q};
        // strap one readable for a fit check
        MCDIO_REG_STRAPS: rdata_d[1:0] = {cfg1_lvl, enc_lvl};
        default: rdata_d = MCDIO_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pol_q <= MCDIO_POLARITY_RST;
      out_q <= MCDIO_OUTPUT_RST;
      st_q <= '0;
      msk_q <= MCDIO_IRQ_MASK_RST;
      sctl_q <= MCDIO_SYNC_CTRL_RST;
      clen_q <= MCDIO_CYCLE_LEN_RST;
      in_on_q <= '0;
      ext_q <= '0;
      sync_prev_q <= 1'b1;
      pulse_q <= 8'h00;
      watch_q <= 16'h0000;
      rdata_q <= MCDIO_RD_ZERO;
      gp_pin_q <= ~MCDIO_OUTPUT_RST;
      sync_out_q <= 1'b0;
      enc_q <= 1'b1;
      emergency_stop_n_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      pol_q <= pol_d;
      out_q <= out_d;
      st_q <= st_d;
      msk_q <= msk_d;
      sctl_q <= sctl_d;
      clen_q <= clen_d;
      in_on_q <= in_on_d;
      ext_q <= ext_d;
      sync_prev_q <= sync_prev_d;
      pulse_q <= pulse_d;
      watch_q <= watch_d;
      rdata_q <= rdata_d;
      gp_pin_q <= gp_pin_d;
      sync_out_q <= sync_out_d;
      enc_q <= enc_d;
      emergency_stop_n_q <= emergency_stop_n_d;
      irq_q <= irq_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign gp_output_1_o = gp_pin_q[0];
  assign gp_output_2_o = gp_pin_q[1];
  assign gp_output_3_o = gp_pin_q[2];
  assign sync_out_o = sync_out_q;
  assign encoder_diff_o = enc_q;
  assign emergency_stop_n_active_o = emergency_stop_n_q;
  assign irq_o = irq_q;
endmodule : mcdio_top

// File: tb/mcdio_asserts.sv
// checker for the digital i/o top: output, read, emergency_stop_n, strap and sync timing
// assumes a bench on the plain register port and a bind at the foot
`timescale 1ns/10ps
module mcdio_asserts (
  input wire logic sys_clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic emergency_stop_n_i, // emergency_stop_n pin
  input wire logic encoder_mode_strap_i, // encoder strap
  input wire logic [mcdio_pkg::MCDIO_ADDR_W-1:0] reg_addr_i, // address
  input wire logic [mcdio_pkg::MCDIO_DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [mcdio_pkg::MCDIO_DATA_W-1:0] reg_rdata_o, // read data
  input wire logic gp_output_1_o, // out 1
  input wire logic gp_output_2_o, // out 2
  input wire logic gp_output_3_o, // out 3
  input wire logic sync_out_o, // sync out
  input wire logic encoder_diff_o, // strap state
  input wire logic emergency_stop_n_active_o, // emergency_stop_n state
  input wire logic irq_o // interrupt
);
  import mcdio_pkg::*;
  logic [2:0] outs;
  assign outs = {gp_output_3_o, gp_output_2_o, gp_output_1_o};
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  out_hold_a: assert property (
    $changed(outs) |-> $past(reg_wr_i) && $past(reg_addr_i) == MCDIO_REG_OUTPUT)
    else $error("outputs moved without a write");
  out_set_a: assert property (
    reg_wr_i && reg_addr_i == MCDIO_REG_OUTPUT |=> outs == ~$past(reg_wdata_i[2:0]))
    else $error("output level wrong after write");
  rd_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == MCDIO_RD_ZERO)
    else $error("read data outside read slot");
  unmap_rd_a: assert property (
    reg_rd_i && reg_addr_i == 4'h2 |=> reg_rdata_o == MCDIO_RD_ZERO)
    else $error("unmapped read not zero");
  emergency_stop_n_on_a: assert property (
    (!emergency_stop_n_i) [*4] |-> emergency_stop_n_active_o)
    else $error("low emergency_stop_n not seen");
  emergency_stop_n_off_a: assert property (
    emergency_stop_n_i [*4] |-> !emergency_stop_n_active_o)
    else $error("idle emergency_stop_n seen active");
  strap_follow_a: assert property (
    $stable(encoder_mode_strap_i) [*4] |-> encoder_diff_o == encoder_mode_strap_i)
    else $error("encoder mode wrong");
  sync_pulse_a: assert property (
    $rose(sync_out_o) |-> sync_out_o [*4] ##1 !sync_out_o)
    else $error("sync pulse width wrong");
  sync_c: cover property ($rose(sync_out_o));
  emergency_stop_n_c: cover property ($rose(emergency_stop_n_active_o));
  irq_c: cover property ($rose(irq_o));
endmodule : mcdio_asserts

bind mcdio_top mcdio_asserts i_mcdio_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .emergency_stop_n_i(emergency_stop_n_i),
  .encoder_mode_strap_i(encoder_mode_strap_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .gp_output_1_o(gp_output_1_o), .gp_output_2_o(gp_output_2_o),
  .gp_output_3_o(gp_output_3_o), .sync_out_o(sync_out_o), .encoder_diff_o(encoder_diff_o),
  .emergency_stop_n_active_o(emergency_stop_n_active_o), .irq_o(irq_o));

// File: tb/mcdio_field.sv
// field side model: switches, interrupt sources, relays, straps, sync source card
// assumes pulled-up pins, so an open switch or idle line reads high
`timescale 1ns/10ps
module mcdio_field (
  input wire logic [9:0] sw_on_i, // closed switches, input register order
  input wire logic [2:0] ext_on_i, // emergency_stop_n, probe0, probe1 pressed
  input wire logic sync_low_i, // source card pulls its line low
  input wire logic enc_diff_i, // encoder strap in 1-2
  input wire logic [2:0] out_pin_i, // output pins 3..1
  output logic [9:0] in_pin_o, // input pins
  output logic [2:0] ext_pin_o, // interrupt pins
  output logic sync_a_o, // sync pin a
  output logic sync_b_o, // sync pin b
  output logic enc_strap_o, // encoder strap
  output logic cfg_strap_o, // first strap
  output logic [2:0] relay_on_o // relay pulled in
);
  assign in_pin_o = ~sw_on_i;
  assign ext_pin_o = ~ext_on_i;
  // source on pin b, pin a on its pull-up
  assign sync_a_o = 1'b1;
  assign sync_b_o = !sync_low_i;
  assign cfg_strap_o = 1'b1;
  assign enc_strap_o = enc_diff_i;
  // relay pulls in on low pin
  assign relay_on_o = ~out_pin_i;
endmodule : mcdio_field

// File: tb/tb.sv
// self-checking bench for the digital i/o block
// assumes the field model on the pins and the checker bound to the top
`timescale 1ns/10ps
module tb;
  import mcdio_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic enc = 1'b1;
  logic sync_low = 1'b0;
  logic [9:0] sw_on = 10'h000;
  logic [2:0] ext_on = 3'h0;
  logic [31:0] rdata;
  logic [9:0] in_pin;
  logic [2:0] ext_pin, relay_on;
  wire [2:0] outs;
  logic sa, sb, es, cs, so, ed, ea, irq;
  logic [2:0] ov [4] = '{3'h5, 3'h2, 3'h7, 3'h0};
  int err_count = 0;
  int checks = 0;
  time t0;
  always #2.5 clk = ~clk;
  mcdio_field i_mcdio_field (.sw_on_i(sw_on), .ext_on_i(ext_on), .sync_low_i(sync_low),
    .enc_diff_i(enc), .out_pin_i(outs), .in_pin_o(in_pin), .ext_pin_o(ext_pin),
    .sync_a_o(sa), .sync_b_o(sb), .enc_strap_o(es), .cfg_strap_o(cs), .relay_on_o(relay_on));
  mcdio_top i_mcdio_top (.sys_clk_i(clk), .rst_i(rst), .ot_pos_n_i(in_pin[9:6]),
    .ot_neg_n_i(in_pin[5:2]), .user_input_4_i(in_pin[1]), .user_input_5_i(in_pin[0]),
    .emergency_stop_n_i(ext_pin[2]), .probe_irq0_n_i(ext_pin[1]), .probe_irq1_n_i(ext_pin[0]),
    .sync_in_a_i(sa), .sync_in_b_i(sb), .encoder_mode_strap_i(es), .config_strap_one_i(cs),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .gp_output_1_o(outs[0]), .gp_output_2_o(outs[1]), .gp_output_3_o(outs[2]),
    .sync_out_o(so), .encoder_diff_o(ed), .emergency_stop_n_active_o(ea), .irq_o(irq));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask : rd_chk
  task automatic wait_rise;
    int n;
    n = 0;
    while (so === 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (so !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 100)
      err_count++;
  endtask : wait_rise
  task automatic summarize;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial
  begin
    #100000;
    err_count++;
    summarize();
  end
  initial
  begin
    cyc(8);
    rst <= 1'b0;
    rd_chk(MCDIO_REG_POLARITY, {22'h0, MCDIO_POLARITY_RST});
    rd_chk(MCDIO_REG_SYNC_CTRL, {MCDIO_CYCLE_LEN_RST, 16'h0});
    cmp(relay_on, 3'h0);
    cyc(1);
    sw_on <= 10'h2c3;
    cyc(5);
    rd_chk(MCDIO_REG_INPUT, 10'h2c3);
    wr_reg(MCDIO_REG_POLARITY, 10'h0f0);
    cyc(3);
    rd_chk(MCDIO_REG_INPUT, 10'h2c3 ^ 10'h0f0);
    foreach (ov[i])
    begin
      wr_reg(MCDIO_REG_OUTPUT, ov[i]);
      wr_reg(4'h3, ~ov[i]);
      cyc(3);
      cmp(relay_on, ov[i]);
      rd_chk(MCDIO_REG_OUTPUT, ov[i]);
    end
    rd_chk(4'h2, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(MCDIO_REG_IRQ_MASK, 32'h0);
      wr_reg(MCDIO_REG_IRQ_STATUS, 32'h3f);
      ext_on <= 3'h4 >> i;
      cyc(6);
      #1 cmp(irq, 1'b0);
      rd_chk(MCDIO_REG_EXT_STATE, 3'h4 >> i);
      cmp(ea, i == 0);
      wr_reg(MCDIO_REG_IRQ_MASK, 6'h1 << i);
      cyc(2);
      #1 cmp(irq, 1'b1);
      wr_reg(MCDIO_REG_IRQ_STATUS, 6'h1 << i);
      ext_on <= 3'h0;
      cyc(2);
      #1 cmp(irq, 1'b0);
    end
    rd_chk(MCDIO_REG_EXT_STATE, 32'h0);
    wr_reg(MCDIO_REG_SYNC_CTRL, 32'h0014_0003);
    wait_rise();
    t0 = $time;
    wait_rise();
    cmp(32'(($time - t0) / 5), 32'h14);
    wr_reg(MCDIO_REG_SYNC_CTRL, 32'h03e8_0002);
    wr_reg(MCDIO_REG_IRQ_MASK, 32'h10);
    wr_reg(MCDIO_REG_IRQ_STATUS, 32'h3f);
    sync_low <= 1'b1;
    cyc(4);
    sync_low <= 1'b0;
    cyc(8);
    #1 cmp(irq, 1'b1);
    cyc(1);
    enc <= 1'b0;
    cyc(5);
    #1 cmp(ed, 1'b0);
    rd_chk(MCDIO_REG_STRAPS, 32'h2);
    summarize();
  end
endmodule : tb
